// file: core/cmd_entry_decode.sv
// decodes connection entries read by the switch fabric each timeslot
module cmd_entry_decode
  import cmd_pkg::*;
#(
  parameter int DEPTH = 1024,
  parameter int AW = 10
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [cmd_pkg::ENTRY_W-1:0] wrData,
  input wire logic rdEn,
  input wire logic [AW-1:0] rdAddr,
  output logic [cmd_pkg::ENTRY_W-1:0] hostRdData,
  input wire logic slotStart,
  input wire logic bitEn,
  input wire logic messageMode,
  input wire cmd_pkg::cmd_rate_t sourceRate,
  input wire logic [7:0] sourceByte,
  output logic [cmd_pkg::GROUP_W-1:0] source_group_sel,
  output logic [cmd_pkg::CHAN_W-1:0] source_channel,
  output logic input_stream_second,
  output cmd_pkg::cmd_voice_t voiceLaw,
  output cmd_pkg::cmd_data_t dataCode,
  output logic isData,
  output logic [7:0] codedByte,
  output logic serialOut,
  output logic reservedError
);
  import cmd_pkg::*;

  logic [ENTRY_W-1:0] memWord;
  logic [ENTRY_W-1:0] entry;
  logic [ENTRY_W-1:0] next_entry;
  logic entryValid;
  logic [GROUP_W-1:0] next_source_group_sel;
  logic [CHAN_W-1:0] next_source_channel;
  logic next_input_stream_second;
  cmd_voice_t next_voiceLaw;
  cmd_data_t next_dataCode;
  logic next_isData;
  logic [7:0] next_codedByte;
  logic next_serialOut;
  logic next_reservedError;
  logic [7:0] shiftReg;
  logic [7:0] next_shiftReg;
  logic [3:0] bitCnt;
  logic [3:0] next_bitCnt;
  logic [ENTRY_W-1:0] next_hostRdData;
  logic pendValid;
  logic next_pendValid;

  function automatic cmd_voice_t voiceOf(input logic [1:0] c);
    case (c)
      2'h0: voiceOf = LAW_A;
      2'h1: voiceOf = LAW_MU;
      2'h2: voiceOf = LAW_A_NOABI;
      default: voiceOf = LAW_MU_NOMAG;
    endcase
  endfunction : voiceOf

  function automatic cmd_data_t dataOf(input logic [1:0] c);
    case (c)
      2'h0: dataOf = DATA_PLAIN;
      2'h1: dataOf = DATA_ABI;
      2'h2: dataOf = DATA_INV_ABI;
      default: dataOf = DATA_INV_ALL;
    endcase
  endfunction : dataOf

  // one read port serves host and fabric alike; rdEn marks a lookup
  cmd_entry_mem #(
    .WIDTH(ENTRY_W),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .sys_clk(sys_clk),
    .wrEn(wrEn),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .rdAddr(rdAddr),
    .rdData(memWord)
  );

  always_comb begin
    next_pendValid = rdEn;
    // hold the looked-up word, so a back-to-back lookup cannot
    // replace it before it is decoded
    next_entry = pendValid ? memWord : entry;
    next_hostRdData = entryValid ? entry : hostRdData;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pendValid <= 1'b0;
      entryValid <= 1'b0;
      entry <= ENTRY_RESET;
      hostRdData <= ENTRY_RESET;
    end else begin
      pendValid <= next_pendValid;
      entryValid <= pendValid;
      entry <= next_entry;
      hostRdData <= next_hostRdData;
    end
  end

  always_comb begin
    logic [1:0] law;
    logic [7:0] mask;
    law = entry[LAW_HI:LAW_LO];
    mask = 8'h00;
    next_source_group_sel = source_group_sel;
    next_source_channel = source_channel;
    next_input_stream_second = input_stream_second;
    next_voiceLaw = voiceLaw;
    next_dataCode = dataCode;
    next_isData = isData;
    next_codedByte = codedByte;
    next_reservedError = reservedError;
    if (entryValid) begin
      next_source_group_sel = entry[GRP_HI:GRP_LO];
      next_isData = entry[VD_BIT];
      next_voiceLaw = voiceOf(law);
      next_dataCode = dataOf(law);
      next_reservedError = |entry[RSV_HI:RSV_LO];
      case (sourceRate)
        RATE_65: begin
          next_source_channel = entry[CH_HI:0];
          next_input_stream_second = 1'b0;
        end
        RATE_32: begin
          next_source_channel = {1'b0, entry[CH_HI:1]};
          next_input_stream_second = entry[0];
        end
        RATE_16: begin
          // eight-bit channel, bit1 must be zero
          next_source_channel = {2'h0, entry[CH_HI:2]};
          next_input_stream_second = entry[0];
          next_reservedError = next_reservedError | entry[1];
        end
        default: begin
          next_source_channel = {3'h0, entry[CH_HI:3]};
          next_input_stream_second = entry[0];
          next_reservedError = next_reservedError | (|entry[2:1]);
        end
      endcase
      // data channel coding of the source byte
      if (entry[VD_BIT]) begin
        case (law)
          2'h1: mask = ABI_MASK;
          2'h2: mask = ~ABI_MASK;
          2'h3: mask = ALL_MASK;
          default: mask = 8'h00;
        endcase
      end
      next_codedByte = sourceByte ^ mask;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      source_group_sel <= '0;
      source_channel <= '0;
      input_stream_second <= 1'b0;
      voiceLaw <= LAW_A;
      dataCode <= DATA_PLAIN;
      isData <= 1'b0;
      codedByte <= 8'h00;
      reservedError <= 1'b0;
    end else begin
      source_group_sel <= next_source_group_sel;
      source_channel <= next_source_channel;
      input_stream_second <= next_input_stream_second;
      voiceLaw <= next_voiceLaw;
      dataCode <= next_dataCode;
      isData <= next_isData;
      codedByte <= next_codedByte;
      reservedError <= next_reservedError;
    end
  end

  // serialiser: the slot byte is loaded at slotStart and shifted per bitEn.
  // bits 9..8 of the entry never reach it in message mode
  always_comb begin
    next_shiftReg = shiftReg;
    next_bitCnt = bitCnt;
    next_serialOut = serialOut;
    if (slotStart) begin
      // message byte is the entry low byte
      next_shiftReg = messageMode ? entry[MSG_HI:0] : codedByte;
      next_bitCnt = SH_BITS;
    end else if (bitEn && bitCnt != 4'h0) begin
      next_serialOut = shiftReg[7];
      next_shiftReg = {shiftReg[6:0], 1'b0};
      next_bitCnt = bitCnt - 4'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      shiftReg <= 8'h00;
      bitCnt <= 4'h0;
      serialOut <= 1'b0;
    end else begin
      shiftReg <= next_shiftReg;
      bitCnt <= next_bitCnt;
      serialOut <= next_serialOut;
    end
  end

  a_group_field: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    entryValid |=> source_group_sel == $past(entry[GRP_HI:GRP_LO]))
    else $error("group field mismatch");

  a_chan_full: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    entryValid && sourceRate == RATE_65 |=>
      source_channel == $past(entry[CH_HI:0]) && !input_stream_second)
    else $error("65M channel mismatch");

  a_chan_32: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    entryValid && sourceRate == RATE_32 |=>
      source_channel == {1'b0, $past(entry[CH_HI:1])} &&
      input_stream_second == $past(entry[0]))
    else $error("32M channel mismatch");

  a_chan_16: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    entryValid && sourceRate == RATE_16 |=>
      source_channel == {2'h0, $past(entry[CH_HI:2])})
    else $error("16M channel mismatch");

  a_chan_8: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    entryValid && sourceRate == RATE_8 |=>
      source_channel == {3'h0, $past(entry[CH_HI:3])})
    else $error("8M channel mismatch");

  a_voice_law: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    entryValid && entry[LAW_HI:LAW_LO] == 2'h2 |=> voiceLaw == LAW_A_NOABI)
    else $error("voice law mismatch");

  a_data_inv: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    entryValid && entry[VD_BIT] && entry[LAW_HI:LAW_LO] == 2'h3 |=>
      codedByte == ~$past(sourceByte))
    else $error("invert all mismatch");

  a_msg_msb: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    slotStart && messageMode ##1 (bitEn && !slotStart) |=>
      serialOut == $past(entry[MSG_HI], 2))
    else $error("message msb not first");

  a_reserved: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    entryValid && (|entry[RSV_HI:RSV_LO]) |=> reservedError)
    else $error("reserved bits not flagged");
endmodule : cmd_entry_decode

// file: common/cmd_pkg.sv
// constants and types for the connection entry decoder
package cmd_pkg;
  localparam int ENTRY_W = 32;
  localparam int CHAN_W = 10;
  localparam int GROUP_W = 5;
  localparam int LAW_HI = 25;
  localparam int LAW_LO = 24;
  localparam int VD_BIT = 28;
  localparam int GRP_HI = 14;
  localparam int GRP_LO = 10;
  localparam int CH_HI = 9;
  localparam int MSG_HI = 7;
  localparam int RSV_HI = 23;
  localparam int RSV_LO = 15;
  localparam logic [31:0] ENTRY_RESET = 32'h0000_0000;
  typedef enum logic [1:0] {
    RATE_8 = 2'h0,
    RATE_16 = 2'h1,
    RATE_32 = 2'h2,
    RATE_65 = 2'h3
  } cmd_rate_t;
  typedef enum logic [3:0] {
    LAW_A = 4'h1,
    LAW_MU = 4'h2,
    LAW_A_NOABI = 4'h4,
    LAW_MU_NOMAG = 4'h8
  } cmd_voice_t;
  typedef enum logic [3:0] {
    DATA_PLAIN = 4'h1,
    DATA_ABI = 4'h2,
    DATA_INV_ABI = 4'h4,
    DATA_INV_ALL = 4'h8
  } cmd_data_t;
  localparam logic [7:0] ABI_MASK = 8'h55;
  localparam logic [7:0] ALL_MASK = 8'hff;
  localparam logic [3:0] SH_BITS = 4'h8;
endpackage : cmd_pkg

// file: core/cmd_entry_mem.sv
// connection entry memory with registered read data
module cmd_entry_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 1024,
  parameter int AW = 10
) (
  input wire logic sys_clk,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic [AW-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_rdData;
  always_comb begin
    next_rdData = mem[rdAddr];
  end
  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= next_rdData;
  end
endmodule : cmd_entry_mem

// file: bench/cmd_host_model.sv
// host-side writer of connection entries
module cmd_host_model
  import cmd_pkg::*;
#(
  parameter int AW = 10
) (
  input wire logic sys_clk,
  output logic wrEn,
  output logic [AW-1:0] wrAddr,
  output logic [cmd_pkg::ENTRY_W-1:0] wrData
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    wrEn = 1'b0;
    wrAddr = '0;
    wrData = '0;
  end

  // gap idles the host first, so slow writers are covered too
  task automatic writeEntry(input logic [AW-1:0] addr,
      input logic [31:0] word, input cmd_rate_t rate, input int gap);
    logic [31:0] w;
    w = word;
    w[RSV_HI:RSV_LO] = '0;
    if (rate == RATE_16) w[1] = 1'b0;
    if (rate == RATE_8) w[2:1] = 2'h0;
    repeat (gap) @(posedge sys_clk);
    @(posedge sys_clk);
    #1;
    wrEn = 1'b1;
    wrAddr = addr;
    wrData = w;
    @(posedge sys_clk);
    #1;
    wrEn = 1'b0;
    // released bus shows the inverse so stale data never looks valid
    wrData = ~w;
  endtask : writeEntry
endmodule : cmd_host_model

// file: bench/tb.sv
// self-checking bench for the connection entry decoder
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import cmd_pkg::*;

  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic wrEn, rdEn, slotStart, bitEn, messageMode;
  logic streamSecond, isData, serialOut, reservedError;
  logic [9:0] wrAddr, rdAddr, chan;
  logic [31:0] wrData, hostRdData;
  logic [7:0] sourceByte, codedByte;
  logic [4:0] groupSel;
  cmd_rate_t sourceRate;
  cmd_voice_t voiceLaw;
  cmd_data_t dataCode;
  int failures = 0;
  int numChecks = 0;

  always #4 sys_clk = ~sys_clk;

  cmd_host_model cmd_host_model_inst (.sys_clk(sys_clk), .wrEn(wrEn),
    .wrAddr(wrAddr), .wrData(wrData));

  cmd_entry_decode cmd_entry_decode_inst (.sys_clk(sys_clk),
    .arst_n(arst_n), .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData),
    .rdEn(rdEn), .rdAddr(rdAddr), .hostRdData(hostRdData),
    .slotStart(slotStart), .bitEn(bitEn), .messageMode(messageMode),
    .sourceRate(sourceRate), .sourceByte(sourceByte),
    .source_group_sel(groupSel), .source_channel(chan),
    .input_stream_second(streamSecond), .voiceLaw(voiceLaw),
    .dataCode(dataCode), .isData(isData), .codedByte(codedByte),
    .serialOut(serialOut), .reservedError(reservedError));

  task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // outputs settle two edges after the request edge
  task automatic lookup(input logic [9:0] addr);
    @(posedge sys_clk);
    #1;
    rdEn = 1'b1;
    rdAddr = addr;
    @(posedge sys_clk);
    #1;
    rdEn = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : lookup

  task automatic testRates();
    logic [31:0] w;
    logic [9:0] ch;
    logic st;
    for (int r = 0; r < 4; r++) begin
      ch = 10'((1024 >> (3 - r)) - 1 - r);
      st = (r < 3) ? ~r[0] : 1'b0;
      w = '0;
      w[14:10] = 5'(31 - 5 * r);
      w[9:0] = 10'((ch << (3 - r)) | st);
      sourceRate = cmd_rate_t'(r);
      cmd_host_model_inst.writeEntry(10'(r), w, sourceRate, r);
      lookup(10'(r));
      check("entry", w, hostRdData);
      check("group", {27'h0, w[14:10]}, {27'h0, groupSel});
      check("channel", {22'h0, ch}, {22'h0, chan});
      check("stream", {31'h0, st}, {31'h0, streamSecond});
      check("reserved", 32'h0, {31'h0, reservedError});
    end
  endtask : testRates

  task automatic testCodes();
    logic [7:0] m [4];
    logic [31:0] w;
    m = '{8'h00, 8'h55, 8'haa, 8'hff};
    for (int k = 0; k < 8; k++) begin
      w = {3'h0, k[2], 2'h0, k[1:0], 24'h0};
      sourceByte = 8'(8'h3c + k);
      cmd_host_model_inst.writeEntry(10'h3ff, w, RATE_65, 0);
      lookup(10'h3ff);
      check("data flag", {31'h0, k[2]}, {31'h0, isData});
      if (k[2] == 1'b0) begin
        check("voice law", 32'h1 << k[1:0], {28'h0, voiceLaw});
        check("voice byte", {24'h0, sourceByte}, {24'h0, codedByte});
      end else begin
        check("data code", 32'h1 << k[1:0], {28'h0, dataCode});
        check("data byte", {24'h0, sourceByte ^ m[k[1:0]]}, {24'h0, codedByte});
      end
    end
  endtask : testCodes

  // loads the slot byte, then shifts all eight bits out
  task automatic shiftSlot(output logic [7:0] got);
    slotStart = 1'b1;
    @(posedge sys_clk);
    #1;
    slotStart = 1'b0;
    bitEn = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      @(posedge sys_clk);
      #1;
      got[i] = serialOut;
    end
    bitEn = 1'b0;
  endtask : shiftSlot

  task automatic testMessage();
    logic [7:0] got;
    messageMode = 1'b1;
    sourceByte = 8'h5a;
    cmd_host_model_inst.writeEntry(10'h2a5, 32'h1300_03a6, RATE_65, 3);
    lookup(10'h2a5);
    shiftSlot(got);
    check("serial byte", 32'ha6, {24'h0, got});
    messageMode = 1'b0;
    // same entry is a data channel with all bits inverted (ALL_MASK)
    shiftSlot(got);
    check("coded serial", {24'h0, 8'h5a ^ ALL_MASK}, {24'h0, got});
  endtask : testMessage

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    rdEn = 1'b0;
    rdAddr = '0;
    slotStart = 1'b0;
    bitEn = 1'b0;
    messageMode = 1'b0;
    sourceRate = RATE_8;
    sourceByte = '0;
    repeat (6) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    check("reset law", 32'h1, {28'h0, voiceLaw});
    testRates();
    testCodes();
    testMessage();
    tally_and_finish();
  end

  // whole run needs about a hundred cycles; allow twenty-fold
  initial begin
    #20000;
    failures++;
    tally_and_finish();
  end
endmodule : tb
